//--- dv/cgrb_bank_props.sv
// Concurrent checks on the ports of the CAN general register bank
module cgrb_bank_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cgrb_pkg::cgrb_core_evt_t coreEvt,
  input wire cgrb_pkg::cgrb_core_cfg_t coreCfg,
  input wire logic [4:0] irqRequest,
  input wire logic canRx,
  input wire logic canTxDominant
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irqCause;
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Causes that may raise the overrun request
  assign irqCause = coreEvt.overrun || (psel && pwrite && pready
    && paddr == cgrb_pkg::OFF_ENABLES);

  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  slverr_map_a: assert property (pready && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > cgrb_pkg::OFF_LAST_IDENT))
    else $error("error response does not match the address map");
  irq_cause_a: assert property ($rose(irqRequest[1]) |->
    $past(irqCause, 1) || $past(irqCause, 2) || $past(irqCause, 3))
    else $error("overrun request rose without event or enable");
  wake_hold_a: assert property (
    canTxDominant && !coreCfg.bitTick |=> canTxDominant)
    else $error("wake pulse ended before the bit ended");
  wake_end_a: assert property (
    canTxDominant && coreCfg.bitTick |=> !canTxDominant)
    else $error("wake pulse longer than one bit");
  wake_standby_a: assert property (
    canTxDominant |-> !coreCfg.nodeRunning)
    else $error("dominant drive while running");
  jump_range_a: assert property (
    coreCfg.jumpQuanta inside {[3'h1:3'h4]})
    else $error("jump width out of range");
  seg_range_a: assert property (coreCfg.seg1Quanta != 5'h00
    && coreCfg.seg2Quanta inside {[4'h1:4'h8]})
    else $error("segment length out of range");
  page_reserved_a: assert property (
    coreCfg.pageReserved == (coreCfg.page > 3'h4))
    else $error("reserved page flag wrong");
  timing_frozen_a: assert property (
    coreCfg.nodeRunning && $past(coreCfg.nodeRunning)
    |-> $stable(coreCfg.seg1Quanta) && $stable(coreCfg.seg2Quanta)
    && $stable(coreCfg.jumpQuanta))
    else $error("bit timing changed while running");

  // Main scenarios reached
  cover property ($rose(canTxDominant));
  cover property (pslverr);
  cover property ($rose(irqRequest[1]));
  cover property (coreCfg.nodeRunning && coreEvt.txErrCount > 9'h0ff);
endmodule : cgrb_bank_props

bind cgrb_register_bank cgrb_bank_props cgrb_bank_props_inst (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .coreEvt(coreEvt),
  .coreCfg(coreCfg), .irqRequest(irqRequest), .canRx(canRx),
  .canTxDominant(canTxDominant)
);

//--- dv/cgrb_can_bus.sv
// Wired bus line standing for the other nodes on the network
module cgrb_can_bus (
  input wire logic canTxDominant,
  input wire logic nodeDom,
  output logic canRx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled recessive unless some party drives dominant
  assign canRx = ~(canTxDominant | nodeDom);
endmodule : cgrb_can_bus

//--- dv/tb_can_general_register_bank.sv
// Self-checking bench for the CAN general register bank
module tb_can_general_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cgrb_pkg::cgrb_core_evt_t coreEvt = '0;
  cgrb_pkg::cgrb_core_cfg_t coreCfg;
  logic [4:0] irqRequest;
  logic canRx;
  logic canTxDominant;
  logic nodeDom = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [7:0] v;
  logic [7:0] t;
  int fails = 0;
  int n_tests = 0;
  int k;
  int w;

  // Clock of the register side
  always #10 core_clk = ~core_clk;

  cgrb_register_bank cgrb_register_bank_inst (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coreEvt(coreEvt), .coreCfg(coreCfg),
    .irqRequest(irqRequest), .canRx(canRx), .canTxDominant(canTxDominant));
  cgrb_can_bus cgrb_can_bus_inst (.canTxDominant(canTxDominant),
    .nodeDom(nodeDom), .canRx(canRx));

  task automatic chk(input string name, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask : rdr

  // Single-cycle event from the protocol core
  task automatic pulse(input cgrb_pkg::cgrb_core_evt_t p);
    @(posedge core_clk);
    coreEvt <= cgrb_pkg::cgrb_core_evt_t'(coreEvt | p);
    @(posedge core_clk);
    coreEvt <= cgrb_pkg::cgrb_core_evt_t'(coreEvt & ~p);
  endtask : pulse

  function automatic cgrb_pkg::cgrb_core_evt_t ev(input int i);
    ev = '0;
    case (i)
      0, 1, 2: ev.rxStored[i] = 1'b1;
      3: ev.txSuccess = 1'b1;
      4: ev.arbWon = 1'b1;
      5: ev.txError = 1'b1;
      6: ev.rxError = 1'b1;
      7: ev.overrun = 1'b1;
      8: ev.readyCleared[1] = 1'b1;
      default: ev.identSeen = 1'b1;
    endcase
  endfunction : ev

  // Flag byte with the pending bit worked out
  function automatic logic [31:0] fl(input logic [7:0] f);
    return {24'h0, f[7:1], |f[3:1]};
  endfunction : fl

  function automatic logic [7:0] rstv(input int i);
    case (i)
      0: return cgrb_pkg::RST_FLAGS;
      1: return cgrb_pkg::RST_ENABLES;
      2: return cgrb_pkg::RST_CONTROL;
      3: return cgrb_pkg::RST_PRESCALER;
      4: return cgrb_pkg::RST_TIMING;
      5: return cgrb_pkg::RST_PAGE;
      default: return cgrb_pkg::RST_LAST_IDENT;
    endcase
  endfunction : rstv

  task automatic print_verdict();
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hung run short
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    k = $urandom(32'hf795);
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (k = 0; k < 7; k++) begin
      rdr(8'(4 * k));
      chk("reset value", {24'h0, rstv(k)}, rd);
    end
    rdr(8'h1c);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    v = 8'($urandom());
    wr(cgrb_pkg::OFF_ENABLES, v);
    rdr(cgrb_pkg::OFF_ENABLES);
    chk("enables", {24'h0, v & cgrb_pkg::WMASK_ENABLES}, rd);
    wr(cgrb_pkg::OFF_ENABLES, 8'h3e);
    for (k = 0; k < 8; k++) pulse(ev(k));
    rdr(cgrb_pkg::OFF_FLAGS);
    chk("flags set", fl(8'hf6), rd);
    chk("irq all", 32'h1b, 32'(irqRequest));
    wr(cgrb_pkg::OFF_FLAGS, 8'hff);
    rdr(cgrb_pkg::OFF_FLAGS);
    chk("flags ones", fl(8'hf6), rd);
    wr(cgrb_pkg::OFF_FLAGS, ~8'h02);
    rdr(cgrb_pkg::OFF_FLAGS);
    chk("flag clear", fl(8'hf4), rd);
    wr(cgrb_pkg::OFF_FLAGS, ~8'h04);
    pulse(ev(8));
    rdr(cgrb_pkg::OFF_FLAGS);
    chk("pending off", fl(8'hb0), rd);
    chk("irq rx tx", 32'h18, 32'(irqRequest));
    wr(cgrb_pkg::OFF_ENABLES, 8'h00);
    repeat (2) @(posedge core_clk);
    chk("irq masked", 32'h0, 32'(irqRequest));
    wr(cgrb_pkg::OFF_FLAGS, 8'h00);
    wr(cgrb_pkg::OFF_ENABLES, 8'h41);
    pulse(ev(3));
    pulse(ev(6));
    pulse(ev(4));
    rdr(cgrb_pkg::OFF_FLAGS);
    chk("early tx", fl(8'h18), rd);
    wr(cgrb_pkg::OFF_FLAGS, 8'h00);
    wr(cgrb_pkg::OFF_ENABLES, 8'h08);
    @(posedge core_clk);
    nodeDom <= 1'b1;
    repeat (4) @(posedge core_clk);
    nodeDom <= 1'b0;
    rdr(cgrb_pkg::OFF_FLAGS);
    chk("standby wake", fl(8'h08), rd);
    chk("irq status", 32'h04, 32'(irqRequest));
    wr(cgrb_pkg::OFF_FLAGS, 8'h00);
    for (k = 0; k < 4; k++) begin
      v = 8'($urandom());
      t = 8'($urandom());
      wr(cgrb_pkg::OFF_PRESCALER, v);
      wr(cgrb_pkg::OFF_TIMING, t);
      rdr(cgrb_pkg::OFF_PRESCALER);
      chk("prescaler", {24'h0, v}, rd);
      rdr(cgrb_pkg::OFF_TIMING);
      chk("timing", {24'h0, t & cgrb_pkg::WMASK_TIMING}, rd);
      chk("jump", 32'(v[7:6]) + 1, 32'(coreCfg.jumpQuanta));
      chk("seg1", 32'(t[3:0]) + 1, 32'(coreCfg.seg1Quanta));
      chk("seg2", 32'(t[6:4]) + 1, 32'(coreCfg.seg2Quanta));
    end
    for (k = 0; k < 8; k++) begin
      wr(cgrb_pkg::OFF_PAGE, 8'(k));
      // The new page is loaded on the commit edge and checked one edge later
      @(posedge core_clk);
      chk("page", 32'(k), 32'(coreCfg.page));
      chk("reserved", 32'(k > 4), 32'(coreCfg.pageReserved));
    end
    v = 8'($urandom());
    coreEvt.identHigh <= v;
    pulse(ev(9));
    rdr(cgrb_pkg::OFF_LAST_IDENT);
    chk("last ident", {24'h0, v}, rd);
    wr(cgrb_pkg::OFF_PRESCALER, 8'h00);
    wr(cgrb_pkg::OFF_TIMING, 8'h11);
    wr(cgrb_pkg::OFF_CONTROL, 8'h1f);
    w = 0;
    while (canTxDominant !== 1'b1 && w < 20) begin
      @(posedge core_clk);
      w++;
    end
    k = 0;
    while (canTxDominant === 1'b1 && k < 100) begin
      @(posedge core_clk);
      k++;
    end
    chk("wake length", 32'd5, 32'(k));
    chk("self rx", 32'h1, 32'(coreCfg.selfReceive));
    chk("no retry", 32'h1, 32'(coreCfg.noRetry));
    rdr(cgrb_pkg::OFF_CONTROL);
    chk("run readback", 32'h1f, rd);
    w = 0;
    while (coreCfg.nodeRunning !== 1'b1 && w < 9000) begin
      @(posedge core_clk);
      w++;
    end
    chk("fast resync", 32'h1, 32'(w < 200));
    wr(cgrb_pkg::OFF_TIMING, 8'h7f);
    rdr(cgrb_pkg::OFF_TIMING);
    chk("timing locked", 32'h11, rd);
    wr(cgrb_pkg::OFF_FLAGS, 8'h00);
    coreEvt.txErrCount <= 9'd200;
    repeat (4) @(posedge core_clk);
    rdr(cgrb_pkg::OFF_CONTROL);
    chk("passive", 32'h3f, rd);
    rdr(cgrb_pkg::OFF_FLAGS);
    chk("passive flag", fl(8'h08), rd);
    coreEvt.txErrCount <= 9'h100;
    repeat (4) @(posedge core_clk);
    rdr(cgrb_pkg::OFF_CONTROL);
    chk("bus off", 32'h5f, rd);
    coreEvt.txErrCount <= 9'h000;
    w = 0;
    while (coreCfg.nodeRunning !== 1'b1 && w < 12000) begin
      @(posedge core_clk);
      w++;
    end
    rdr(cgrb_pkg::OFF_CONTROL);
    chk("rejoined", 32'h1f, rd);
    coreEvt.transferActive <= 1'b1;
    wr(cgrb_pkg::OFF_CONTROL, 8'h1e);
    rdr(cgrb_pkg::OFF_CONTROL);
    chk("stop pending", 32'h1f, rd);
    coreEvt.transferActive <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdr(cgrb_pkg::OFF_CONTROL);
    chk("standby", 32'h1e, rd);
    print_verdict();
  end
endmodule : tb_can_general_register_bank

//--- verilog/cgrb_pkg.sv
// Package with the register map, field layout and types of the bank
package cgrb_pkg;
  // Register byte addresses on the APB side
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ENABLES = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_PRESCALER = 8'h0c;
  localparam logic [7:0] OFF_TIMING = 8'h10;
  localparam logic [7:0] OFF_PAGE = 8'h14;
  localparam logic [7:0] OFF_LAST_IDENT = 8'h18;
  // Reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PRESCALER = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h23;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_LAST_IDENT = 8'h00;
  // Writable bits of each register
  localparam logic [7:0] WMASK_ENABLES = 8'h7f;
  localparam logic [7:0] WMASK_CONTROL = 8'h1f;
  localparam logic [7:0] WMASK_TIMING = 8'h7f;
  localparam logic [7:0] WMASK_PAGE = 8'h07;
  // Interrupt flag bit positions
  localparam int FLG_RX1 = 5;
  localparam int FLG_TX = 4;
  localparam int FLG_SC = 3;
  localparam int FLG_OR = 2;
  localparam int FLG_TE = 1;
  localparam int FLG_PEND = 0;
  // Interrupt enable bit positions
  localparam int EN_EXTENDED_STATUS_IRQ = 6;
  localparam int EN_RX = 5;
  localparam int EN_TX = 4;
  localparam int EN_SC = 3;
  localparam int EN_OR = 2;
  localparam int EN_TE = 1;
  localparam int EN_ETX = 0;
  // Node control/status bit positions
  localparam int CS_BUS_OFF_STATE = 6;
  localparam int CS_ERROR_PASSIVE_STATE = 5;
  localparam int CS_SELF_RECEIVE_ENABLE = 4;
  localparam int CS_NO_RETRY = 3;
  localparam int CS_FAST_RESYNC = 2;
  localparam int CS_WAKE_PULSE_ENABLE = 1;
  localparam int CS_RUN = 0;
  // Field positions of prescaler, timing and page registers
  localparam int PRE_JW_LSB = 6;
  localparam int PRE_BRP_MSB = 5;
  localparam int TIM_BS2_MSB = 6;
  localparam int TIM_BS2_LSB = 4;
  localparam int TIM_BS1_MSB = 3;
  localparam int PAGE_MSB = 2;
  localparam logic [2:0] PAGE_LAST_VALID = 3'h4;
  // Bus timing figures and error counter limits
  localparam logic [3:0] RECESSIVE_RUN_BITS = 4'hb;
  localparam logic [7:0] STD_RESYNC_RUNS = 8'h80;
  localparam logic [7:0] FAST_RESYNC_RUNS = 8'h01;
  localparam logic [4:0] SEG_OVERHEAD = 5'h03;
  localparam logic [8:0] TEC_PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] TEC_BUSOFF_LIMIT = 9'h0ff;
  localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7f;

  // Controller modes
  typedef enum logic [1:0] {
    ST_STANDBY, ST_WAKE, ST_RESYNC, ST_RUN
  } cgrb_state_t;

  // Events and state reported by the protocol core, same clock
  typedef struct packed {
    logic [2:0] rxStored;
    logic [2:0] readyCleared;
    logic txSuccess;
    logic arbWon;
    logic txError;
    logic rxError;
    logic overrun;
    logic identSeen;
    logic [7:0] identHigh;
    logic transferActive;
    logic [8:0] txErrCount;
    logic [7:0] rxErrCount;
  } cgrb_core_evt_t;

  // Configuration and timing handed to the protocol core
  typedef struct packed {
    logic selfReceive;
    logic noRetry;
    logic nodeRunning;
    logic quantumTick;
    logic bitTick;
    logic [2:0] jumpQuanta;
    logic [4:0] seg1Quanta;
    logic [3:0] seg2Quanta;
    logic [2:0] page;
    logic pageReserved;
  } cgrb_core_cfg_t;
endpackage : cgrb_pkg

//--- verilog/cgrb_register_bank.sv
// General register bank of the CAN controller with APB access
// Operation
// - Receive flags set on store, cleared by software
// - Transmit flag on completion, or arbitration if early
// - Status flag on standby dominant or error escalation
// - Extended mode adds every receive error
// - Overrun flag when no receive buffer free
// - Transmit error flag on transmit error
// - Error pending follows three error flags
// - Writing zero clears a flag
// - Interrupt request per event gated by enable
// - Bus-off above 255, cleared on rejoining bus
// - Error passive bit only while error passive
// - Self reception switch passed to core
// - No-retry switch passed to core
// - Resync after one or 128 recessive runs
// - Optional dominant wake pulse leaving standby
// - Run bit reads one until standby reached
// - Quantum is clock times prescale plus one
// - Jump width is field plus one quanta
// - Segment lengths field plus one, reset 23h
// - Bit period is segments sum plus one
// - Timing writes accepted only in standby
// - Page field selects the paged window
// - Capture last identifier high bits
// - Wake pulse lasts exactly one bit time
// - Identifier kept until overwritten by newer one or a software write
// - Error passive above counter value 127
module cgrb_register_bank (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cgrb_pkg::cgrb_core_evt_t coreEvt,
  output cgrb_pkg::cgrb_core_cfg_t coreCfg,
  output logic [4:0] irqRequest,
  input wire logic canRx,
  output logic canTxDominant
);
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] control;
  logic [7:0] prescaler;
  logic [7:0] timing;
  logic [7:0] page;
  logic [7:0] lastIdent;
  logic busOffState;
  logic errorPassiveState;
  cgrb_pkg::cgrb_state_t state;
  logic stopPending;
  logic rxMeta;
  logic rxSync;
  logic rxPrev;
  logic [5:0] quantumCount;
  logic [4:0] quantumInBit;
  logic quantumTick;
  logic bitTick;
  logic [3:0] recessiveRun;
  logic [7:0] runCount;
  logic passivePrev;
  logic busOffPrev;
  logic tecOverPrev;
  logic [2:0] jumpQuanta;
  logic [4:0] seg1Quanta;
  logic [3:0] seg2Quanta;
  logic [7:0] readValue;
  logic addrHit;
  logic commit;
  logic writeStrobe;
  logic [7:0] wdata;
  logic [7:0] flagClear;
  logic [7:0] flagSet;
  logic nodePassive;
  logic tecOver;
  logic [7:0] resyncNeed;
  logic [4:0] bitLastQuantum;
  logic pageReserved;

  // APB request decode
  assign commit = psel & penable & pready;
  assign writeStrobe = commit & pwrite & addrHit;
  assign wdata = pwdata[7:0];

  // Read multiplexer; upper data bits read as zero
  always_comb begin
    addrHit = 1'b1;
    readValue = 8'h00;
    case (paddr)
      cgrb_pkg::OFF_FLAGS: readValue = flags;
      cgrb_pkg::OFF_ENABLES: readValue = enables;
      cgrb_pkg::OFF_CONTROL: begin
        readValue = control;
        readValue[cgrb_pkg::CS_BUS_OFF_STATE] = busOffState;
        readValue[cgrb_pkg::CS_ERROR_PASSIVE_STATE] = errorPassiveState;
        readValue[cgrb_pkg::CS_RUN] = (state != cgrb_pkg::ST_STANDBY);
      end
      cgrb_pkg::OFF_PRESCALER: readValue = prescaler;
      cgrb_pkg::OFF_TIMING: readValue = timing;
      cgrb_pkg::OFF_PAGE: readValue = page;
      cgrb_pkg::OFF_LAST_IDENT: readValue = lastIdent;
      default: addrHit = 1'b0;
    endcase
  end

  // One wait state: answer is registered in the first access cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel & penable & ~pready) begin
      pready <= 1'b1;
      pslverr <= ~addrHit;
      prdata <= {24'h000000, readValue};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Flag events from the core and the bus
  always_comb begin
    flagSet = 8'h00;
    flagClear = 8'h00;
    for (int i = 0; i < 3; i++) begin
      flagSet[cgrb_pkg::FLG_RX1 + i] = coreEvt.rxStored[i];
      flagClear[cgrb_pkg::FLG_RX1 + i] = coreEvt.readyCleared[i];
    end
    flagSet[cgrb_pkg::FLG_TX] = enables[cgrb_pkg::EN_ETX] ?
        coreEvt.arbWon : coreEvt.txSuccess;
    flagSet[cgrb_pkg::FLG_SC] =
        (state == cgrb_pkg::ST_STANDBY && rxPrev && !rxSync) ||
        (state == cgrb_pkg::ST_RUN &&
         ((nodePassive && !passivePrev) || (busOffState && !busOffPrev)))
        || (enables[cgrb_pkg::EN_EXTENDED_STATUS_IRQ] && coreEvt.rxError);
    flagSet[cgrb_pkg::FLG_OR] = coreEvt.overrun;
    flagSet[cgrb_pkg::FLG_TE] = coreEvt.txError;
    if (writeStrobe && paddr == cgrb_pkg::OFF_FLAGS) begin
      flagClear = flagClear | ~wdata;
    end
    flagClear[cgrb_pkg::FLG_PEND] = 1'b0;
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags <= cgrb_pkg::RST_FLAGS;
    end else begin
      flags[7:1] <= (flags[7:1] & ~flagClear[7:1]) | flagSet[7:1];
      flags[cgrb_pkg::FLG_PEND] <=
          |(((flags & ~flagClear) | flagSet) & 8'h0e);
    end
  end

  // Interrupt requests gated by their enables
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irqRequest <= 5'h00;
    end else begin
      irqRequest[4] <= enables[cgrb_pkg::EN_RX] & (|flags[7:5]);
      irqRequest[3] <= enables[cgrb_pkg::EN_TX] & flags[cgrb_pkg::FLG_TX];
      irqRequest[2] <= enables[cgrb_pkg::EN_SC] & flags[cgrb_pkg::FLG_SC];
      irqRequest[1] <= enables[cgrb_pkg::EN_OR] & flags[cgrb_pkg::FLG_OR];
      irqRequest[0] <= enables[cgrb_pkg::EN_TE] & flags[cgrb_pkg::FLG_TE];
    end
  end

  // Interrupt enables and page selector
  always_ff @(posedge core_clk) begin
    if (reset) begin
      enables <= cgrb_pkg::RST_ENABLES;
      page <= cgrb_pkg::RST_PAGE;
      pageReserved <= 1'b0;
    end else if (writeStrobe) begin
      if (paddr == cgrb_pkg::OFF_ENABLES) begin
        enables <= wdata & cgrb_pkg::WMASK_ENABLES;
      end
      if (paddr == cgrb_pkg::OFF_PAGE) begin
        page <= wdata & cgrb_pkg::WMASK_PAGE;
        pageReserved <= wdata[cgrb_pkg::PAGE_MSB:0] >
            cgrb_pkg::PAGE_LAST_VALID;
      end
    end
  end

  // Control switches; the run bit is kept as the request only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      control <= cgrb_pkg::RST_CONTROL;
    end else if (writeStrobe && paddr == cgrb_pkg::OFF_CONTROL) begin
      control <= wdata & cgrb_pkg::WMASK_CONTROL;
    end
  end

  // Bit timing registers, writable only in standby
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescaler <= cgrb_pkg::RST_PRESCALER;
      timing <= cgrb_pkg::RST_TIMING;
    end else if (writeStrobe && state == cgrb_pkg::ST_STANDBY) begin
      if (paddr == cgrb_pkg::OFF_PRESCALER) begin
        prescaler <= wdata;
      end
      if (paddr == cgrb_pkg::OFF_TIMING) begin
        timing <= wdata & cgrb_pkg::WMASK_TIMING;
      end
    end
  end

  // Last identifier capture; a newer one from the bus overwrites
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lastIdent <= cgrb_pkg::RST_LAST_IDENT;
    end else if (coreEvt.identSeen) begin
      lastIdent <= coreEvt.identHigh;
    end else if (writeStrobe && paddr == cgrb_pkg::OFF_LAST_IDENT) begin
      lastIdent <= wdata;
    end
  end

  // Bus receive pin synchroniser and edge history
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= canRx;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end

  // Error confinement state from the core counters
  assign tecOver = coreEvt.txErrCount > cgrb_pkg::TEC_BUSOFF_LIMIT;
  assign nodePassive = !busOffState &&
      (coreEvt.txErrCount > cgrb_pkg::TEC_PASSIVE_LIMIT ||
       coreEvt.rxErrCount > cgrb_pkg::REC_PASSIVE_LIMIT);

  // Bus-off and error-passive status bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busOffState <= 1'b0;
      errorPassiveState <= 1'b0;
      tecOverPrev <= 1'b0;
      passivePrev <= 1'b0;
      busOffPrev <= 1'b0;
    end else begin
      tecOverPrev <= tecOver;
      passivePrev <= nodePassive;
      busOffPrev <= busOffState;
      errorPassiveState <= nodePassive;
      if (tecOver && !tecOverPrev) begin
        busOffState <= 1'b1;
      end else if (state == cgrb_pkg::ST_RESYNC && bitTick &&
                   runCount == resyncNeed) begin
        busOffState <= 1'b0;
      end
    end
  end

  // Quantum prescaler and bit period counter, stopped in standby
  assign bitLastQuantum = seg1Quanta + 5'(seg2Quanta) - 5'h01 +
      cgrb_pkg::SEG_OVERHEAD - 5'h02;
  always_ff @(posedge core_clk) begin
    if (reset || state == cgrb_pkg::ST_STANDBY) begin
      quantumCount <= 6'h00;
      quantumInBit <= 5'h00;
      quantumTick <= 1'b0;
      bitTick <= 1'b0;
    end else begin
      quantumTick <= 1'b0;
      bitTick <= 1'b0;
      if (quantumCount == prescaler[cgrb_pkg::PRE_BRP_MSB:0]) begin
        quantumCount <= 6'h00;
        quantumTick <= 1'b1;
        if (quantumInBit == bitLastQuantum) begin
          quantumInBit <= 5'h00;
          bitTick <= 1'b1;
        end else begin
          quantumInBit <= quantumInBit + 5'h01;
        end
      end else begin
        quantumCount <= quantumCount + 6'h01;
      end
    end
  end

  // Segment and jump width lengths in quanta
  always_ff @(posedge core_clk) begin
    if (reset) begin
      jumpQuanta <= 3'h1;
      seg1Quanta <= 5'h01;
      seg2Quanta <= 4'h1;
    end else begin
      jumpQuanta <= {1'b0, prescaler[7:cgrb_pkg::PRE_JW_LSB]} + 3'h1;
      seg1Quanta <= {1'b0, timing[cgrb_pkg::TIM_BS1_MSB:0]} + 5'h01;
      seg2Quanta <= {1'b0,
          timing[cgrb_pkg::TIM_BS2_MSB:cgrb_pkg::TIM_BS2_LSB]} + 4'h1;
    end
  end

  // Number of recessive runs needed before joining the bus
  assign resyncNeed = (control[cgrb_pkg::CS_FAST_RESYNC] && !busOffState) ?
      cgrb_pkg::FAST_RESYNC_RUNS : cgrb_pkg::STD_RESYNC_RUNS;

  // Mode sequencer: standby, wake pulse, resync and run
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= cgrb_pkg::ST_STANDBY;
      stopPending <= 1'b0;
    end else begin
      if (writeStrobe && paddr == cgrb_pkg::OFF_CONTROL) begin
        stopPending <= !wdata[cgrb_pkg::CS_RUN] &&
            state != cgrb_pkg::ST_STANDBY;
      end
      case (state)
        cgrb_pkg::ST_STANDBY: begin
          stopPending <= 1'b0;
          if (writeStrobe && paddr == cgrb_pkg::OFF_CONTROL &&
              wdata[cgrb_pkg::CS_RUN]) begin
            state <= wdata[cgrb_pkg::CS_WAKE_PULSE_ENABLE] ? cgrb_pkg::ST_WAKE :
                cgrb_pkg::ST_RESYNC;
          end
        end
        cgrb_pkg::ST_WAKE: begin
          if (bitTick) begin
            state <= cgrb_pkg::ST_RESYNC;
          end
        end
        cgrb_pkg::ST_RESYNC: begin
          if (stopPending) begin
            state <= cgrb_pkg::ST_STANDBY;
          end else if (bitTick && runCount == resyncNeed) begin
            state <= cgrb_pkg::ST_RUN;
          end
        end
        cgrb_pkg::ST_RUN: begin
          if (stopPending && !coreEvt.transferActive) begin
            state <= cgrb_pkg::ST_STANDBY;
          end else if (busOffState) begin
            state <= cgrb_pkg::ST_RESYNC;
          end
        end
        default: state <= cgrb_pkg::ST_STANDBY;
      endcase
    end
  end

  // Recessive run counting during resync
  always_ff @(posedge core_clk) begin
    if (reset || state != cgrb_pkg::ST_RESYNC) begin
      recessiveRun <= 4'h0;
      runCount <= 8'h00;
    end else if (bitTick) begin
      if (!rxSync) begin
        recessiveRun <= 4'h0;
      end else if (recessiveRun + 4'h1 == cgrb_pkg::RECESSIVE_RUN_BITS) begin
        recessiveRun <= 4'h0;
        runCount <= runCount + 8'h01;
      end else begin
        recessiveRun <= recessiveRun + 4'h1;
      end
    end
  end

  // Dominant wake pulse for one bit time
  always_ff @(posedge core_clk) begin
    if (reset) begin
      canTxDominant <= 1'b0;
    end else begin
      canTxDominant <= state == cgrb_pkg::ST_WAKE && !bitTick;
    end
  end

  // Configuration handed to the core, all from flops
  logic nodeRunning;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nodeRunning <= 1'b0;
    end else begin
      nodeRunning <= state == cgrb_pkg::ST_RUN;
    end
  end

  assign coreCfg = '{
    selfReceive: control[cgrb_pkg::CS_SELF_RECEIVE_ENABLE],
    noRetry: control[cgrb_pkg::CS_NO_RETRY],
    nodeRunning: nodeRunning,
    quantumTick: quantumTick,
    bitTick: bitTick,
    jumpQuanta: jumpQuanta,
    seg1Quanta: seg1Quanta,
    seg2Quanta: seg2Quanta,
    page: page[cgrb_pkg::PAGE_MSB:0],
    pageReserved: pageReserved
  };
endmodule : cgrb_register_bank
